// ### common/output_volume_control_consts.vh
// constants for the output volume control register bank
`ifndef OUTPUT_VOLUME_CONTROL_CONSTS_VH
`define OUTPUT_VOLUME_CONTROL_CONSTS_VH

// register indices; byte address is four times the index
`define OVC_IDX_PHONES_LEFT   8'h39
`define OVC_IDX_PHONES_RIGHT  8'h3a
`define OVC_IDX_LINE_LEFT     8'h3b
`define OVC_IDX_LINE_RIGHT    8'h3c
`define OVC_IDX_CONTROL       8'h3d
`define OVC_IDX_STATUS        8'h3e

// channel register fields
`define OVC_BIT_SILENCE       8
`define OVC_BIT_COMMIT        7
`define OVC_BIT_ZC_ENABLE     6
`define OVC_GAIN_MSB          5
`define OVC_GAIN_LSB          0

// control register fields
`define OVC_BIT_TIMEOUT_EN    0

// reset values
`define OVC_RST_PHONES_GAIN   6'h2d
`define OVC_RST_LINE_GAIN     6'h39
`define OVC_RST_SILENCE       1'h0
`define OVC_RST_ZC_ENABLE     1'h0
`define OVC_RST_TIMEOUT_EN    1'h0

// zero-cross timeout: 1000 us at a 100 MHz clock, sized for the 17-bit counter
`define OVC_ZC_TIMEOUT_CYCLES 17'h186a0

// register selector codes
`define OVC_SEL_CONTROL       3'h4
`define OVC_SEL_STATUS        3'h5
`define OVC_SEL_NONE          3'h7

// bus responses
`define OVC_RESP_OKAY         2'h0
`define OVC_RESP_SLVERR       2'h2

`endif

// ### hdl/output_volume_control.v
// output volume and mute control for the phones and line output pairs
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "output_volume_control_consts.vh"

module output_volume_control #(
	parameter [16:0] ZC_TIMEOUT_CYCLES = `OVC_ZC_TIMEOUT_CYCLES
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [9:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [9:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        phones_left_pin_zero_cross,
	input  wire        phones_right_pin_zero_cross,
	input  wire        line_left_pin_zero_cross,
	input  wire        line_right_pin_zero_cross,
	output wire [5:0]  phones_left_pin_gain,
	output wire [5:0]  phones_right_pin_gain,
	output wire [5:0]  line_left_pin_gain,
	output wire [5:0]  line_right_pin_gain,
	output wire        phones_left_pin_silence,
	output wire        phones_right_pin_silence,
	output wire        line_left_pin_silence,
	output wire        line_right_pin_silence
);

////////////////////////////////////////////////////////////////////////////////
// address decode

// map a byte address to a register selector; low two bits ignored
// registers sit at word indices, so the byte address is four times the index
// channel selectors 0 to 3 follow the order of the generate loop below
function [2:0] reg_sel;
	input [9:0] addr;
	begin
		case (addr[9:2])
			`OVC_IDX_PHONES_LEFT:  reg_sel = 3'h0;
			`OVC_IDX_PHONES_RIGHT: reg_sel = 3'h1;
			`OVC_IDX_LINE_LEFT:    reg_sel = 3'h2;
			`OVC_IDX_LINE_RIGHT:   reg_sel = 3'h3;
			`OVC_IDX_CONTROL:      reg_sel = `OVC_SEL_CONTROL;
			`OVC_IDX_STATUS:       reg_sel = `OVC_SEL_STATUS;
			default:               reg_sel = `OVC_SEL_NONE;
		endcase
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// bus write side state
// each write channel is a one-deep holding slot; a master may offer
// address and data in either order and the write waits for both

reg        aw_full_reg;    // write address held
reg [9:0]  aw_addr_reg;    // held write address
reg        w_full_reg;     // write data held
reg [31:0] w_data_reg;     // held write data
reg [3:0]  w_strb_reg;     // held byte enables
reg        bvalid_reg;     // write response pending
reg [1:0]  bresp_reg;      // write response code

// bus read side state
// a single answer slot; the next read address waits until it is collected
reg        rvalid_reg;     // read data pending
reg [31:0] rdata_reg;      // read data word
reg [1:0]  rresp_reg;      // read response code

// block state shared by all channels
// flat vectors carry per-channel state out of the generate loop
reg        timeout_en_reg; // zc_timeout_enable
wire [35:0] field_flat;    // stored channel words, 9 bits each
wire [23:0] applied_flat;  // gains in force at the pins
wire [3:0]  pending_flat;  // channel holds a gain not yet applied
wire [3:0]  zc_in;         // zero-cross events per channel

// crossing detectors arrive already synchronous to the system clock
assign zc_in = {line_right_pin_zero_cross, line_left_pin_zero_cross,
	phones_right_pin_zero_cross, phones_left_pin_zero_cross};

////////////////////////////////////////////////////////////////////////////////
// handshake outputs

// address and data are taken independently, one of each at a time
assign s_axi_awready = !aw_full_reg;
assign s_axi_wready  = !w_full_reg;
assign s_axi_bvalid  = bvalid_reg;
assign s_axi_bresp   = bresp_reg;
// no new read is taken until the previous answer is collected
assign s_axi_arready = !rvalid_reg;
assign s_axi_rvalid  = rvalid_reg;
assign s_axi_rdata   = rdata_reg;
assign s_axi_rresp   = rresp_reg;

////////////////////////////////////////////////////////////////////////////////
// write decode

wire       wr_fire;        // register write happens this cycle
wire [2:0] wr_sel;         // target of the held address
wire [1:0] commit;         // pair commit strobe: bit 0 phones, bit 1 line

// the write waits until the last response has been taken
// so a slow bready stalls further writes instead of losing a response
assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
assign wr_sel  = reg_sel(aw_addr_reg);

// commit is a pure strobe, never stored
// selectors 0 and 1 form the phones pair, 2 and 3 the line pair; a write
// with bit 7 clear moves an applied gain only by clearing the zc enable of a waiting channel
assign commit[0] = wr_fire && w_strb_reg[0] && w_data_reg[`OVC_BIT_COMMIT] &&
	(wr_sel[2:1] == 2'h0);
assign commit[1] = wr_fire && w_strb_reg[0] && w_data_reg[`OVC_BIT_COMMIT] &&
	(wr_sel[2:1] == 2'h1);

////////////////////////////////////////////////////////////////////////////////
// bus channel capture and write response
// a slot fills when its channel handshakes and empties when the write executes

always @(posedge aclk) begin
	if (!aresetn) begin
		aw_full_reg <= 1'b0;
		aw_addr_reg <= 10'h000;
		w_full_reg  <= 1'b0;
		w_data_reg  <= 32'h00000000;
		w_strb_reg  <= 4'h0;
		bvalid_reg  <= 1'b0;
		bresp_reg   <= `OVC_RESP_OKAY;
	end else begin
		// capture address
		if (s_axi_awvalid && !aw_full_reg) begin
			aw_full_reg <= 1'b1;
			aw_addr_reg <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_full_reg <= 1'b0;
		end
		// capture data
		if (s_axi_wvalid && !w_full_reg) begin
			w_full_reg <= 1'b1;
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_full_reg <= 1'b0;
		end
		// response; unmapped or status writes are refused with an error
		if (wr_fire) begin
			bvalid_reg <= 1'b1;
			if (wr_sel == `OVC_SEL_NONE || wr_sel == `OVC_SEL_STATUS) begin
				bresp_reg <= `OVC_RESP_SLVERR;
			end else begin
				bresp_reg <= `OVC_RESP_OKAY;
			end
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// control register
// only bit 0 is kept; the other bits read back as zero
// clearing the enable freezes every running timeout count where it stands

always @(posedge aclk) begin
	if (!aresetn) begin
		timeout_en_reg <= `OVC_RST_TIMEOUT_EN;
	end else if (wr_fire && wr_sel == `OVC_SEL_CONTROL && w_strb_reg[0]) begin
		timeout_en_reg <= w_data_reg[`OVC_BIT_TIMEOUT_EN];
	end
end

////////////////////////////////////////////////////////////////////////////////
// per-channel storage, zero-cross gating and timeout
// each channel keeps three gains: the stored code, the committed target and
// the code in force at the pin; only the last one reaches the output stage

genvar c;
generate
	for (c = 0; c < 4; c = c + 1) begin : chan
		// phones channels 0 and 1, line channels 2 and 3
		localparam [5:0] RST_GAIN = (c < 2) ? `OVC_RST_PHONES_GAIN :
			`OVC_RST_LINE_GAIN;
		reg  [8:0]  field_reg;   // silence, zero (commit), zc enable, gain
		reg  [5:0]  applied_reg; // gain driven to the pin
		reg  [5:0]  target_reg;  // committed gain awaiting a crossing
		reg         pending_reg; // target not yet applied
		reg  [16:0] tmo_reg;     // cycles waited for a crossing
		reg  [8:0]  field_next;
		wire        hit;         // this channel's register is written
		wire        pair_commit; // commit of the pair this channel belongs to
		wire        expired;     // timeout reached

		assign hit         = wr_fire && (wr_sel == c);
		assign pair_commit = commit[c / 2];
		assign expired     = timeout_en_reg &&
			(tmo_reg == ZC_TIMEOUT_CYCLES - 17'h00001);

		// byte lanes: lane 0 holds zc and gain, lane 1 holds silence
		// bit 7 is stored as zero so the commit strobe never reads back as one
		always @* begin
			field_next = field_reg;
			if (hit && w_strb_reg[0]) begin
				field_next[7:0] = {1'b0, w_data_reg[6:0]};
			end
			if (hit && w_strb_reg[1]) begin
				field_next[`OVC_BIT_SILENCE] = w_data_reg[`OVC_BIT_SILENCE];
			end
		end

		// gain only moves on a commit; the stored code alone changes nothing
		// the committing write brings its own zc enable, the partner uses its
		// stored one; a new commit while waiting restarts the wait
		always @(posedge aclk) begin
			if (!aresetn) begin
				field_reg   <= {`OVC_RST_SILENCE, 1'b0, `OVC_RST_ZC_ENABLE,
					RST_GAIN};
				applied_reg <= RST_GAIN;
				target_reg  <= RST_GAIN;
				pending_reg <= 1'b0;
				tmo_reg     <= 17'h00000;
			end else begin
				field_reg <= field_next;
				if (pair_commit) begin
					target_reg <= field_next[`OVC_GAIN_MSB:`OVC_GAIN_LSB];
					tmo_reg    <= 17'h00000;
					if (field_next[`OVC_BIT_ZC_ENABLE]) begin
						// hold until this channel's own crossing
						pending_reg <= 1'b1;
					end else begin
						// zc off: the new code goes straight to the pin
						applied_reg <= field_next[`OVC_GAIN_MSB:`OVC_GAIN_LSB];
						pending_reg <= 1'b0;
					end
				end else if (pending_reg) begin
					// a cleared zc enable releases the wait at once
					if (zc_in[c] || expired || !field_reg[`OVC_BIT_ZC_ENABLE]) begin
						applied_reg <= target_reg;
						pending_reg <= 1'b0;
						tmo_reg     <= 17'h00000;
					end else if (timeout_en_reg) begin
						// count only while the timeout is enabled
						tmo_reg <= tmo_reg + 17'h00001;
					end
				end
			end
		end

		// export channel state to the shared read and pin logic
		assign field_flat[c*9 +: 9]   = field_reg;
		assign applied_flat[c*6 +: 6] = applied_reg;
		assign pending_flat[c]        = pending_reg;
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// read path
// the answer is captured in the cycle the address is taken,
// so a later write cannot change a read already under way

wire [2:0] rd_sel;         // target of the read address
reg  [31:0] rd_word;       // word for the addressed register
reg  [1:0]  rd_resp;       // response for the addressed register

assign rd_sel = reg_sel(s_axi_araddr);

// commit bit is held zero in storage, so it reads back 0
always @* begin
	rd_word = 32'h00000000;
	rd_resp = `OVC_RESP_OKAY;
	case (rd_sel)
		3'h0, 3'h1, 3'h2, 3'h3: begin
			rd_word = {23'h000000, field_flat[rd_sel[1:0]*9 +: 9]};
		end
		`OVC_SEL_CONTROL: begin
			rd_word = {31'h00000000, timeout_en_reg};
		end
		`OVC_SEL_STATUS: begin
			rd_word = {28'h0000000, pending_flat};
		end
		default: begin
			// unmapped reads return zero with an error
			rd_resp = `OVC_RESP_SLVERR;
		end
	endcase
end

// one-cycle read answer, held until rready
always @(posedge aclk) begin
	if (!aresetn) begin
		rvalid_reg <= 1'b0;
		rdata_reg  <= 32'h00000000;
		rresp_reg  <= `OVC_RESP_OKAY;
	end else if (s_axi_arvalid && !rvalid_reg) begin
		rvalid_reg <= 1'b1;
		rdata_reg  <= rd_word;
		rresp_reg  <= rd_resp;
	end else if (s_axi_rready) begin
		rvalid_reg <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// pin drive; gain code n means (n - 57) dB at the output stage
// so 111001 is unity gain and the all-ones code is the top of the range

assign phones_left_pin_gain     = applied_flat[5:0];
assign phones_right_pin_gain    = applied_flat[11:6];
assign line_left_pin_gain       = applied_flat[17:12];
assign line_right_pin_gain      = applied_flat[23:18];
// mute acts at once, it does not wait for commit or crossing
assign phones_left_pin_silence  = field_flat[8];
assign phones_right_pin_silence = field_flat[17];
assign line_left_pin_silence    = field_flat[26];
assign line_right_pin_silence   = field_flat[35];

endmodule

// ### tb/output_volume_control_asserts.sv
// bus and gain checks for the output volume control register bank
`timescale 1ns/1ps
module output_volume_control_asserts #(
	parameter [16:0] ZC_TIMEOUT_CYCLES = 17'h14
) (
	input wire        aclk,
	input wire        aresetn,
	input wire [9:0]  s_axi_awaddr,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0]  s_axi_wstrb,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [5:0]  phones_left_pin_gain,
	input wire [5:0]  line_right_pin_gain,
	input wire        phones_left_pin_silence
);
	// address and data taken at one edge with no response waiting
	wire       wr_go = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready & !s_axi_bvalid;
	wire [7:0] wr_ix = s_axi_awaddr[9:2];
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while data waits");
	AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_WR_LAT: assert property (wr_go |=> ##1 s_axi_bvalid)
		else $error("write answer late");
	AST_COMMIT_RD0: assert property (s_axi_rvalid |-> !s_axi_rdata[7])
		else $error("commit bit read back as one");
	AST_SILENCE: assert property (wr_go && wr_ix == 8'h39 && s_axi_wstrb[1]
		|=> ##1 phones_left_pin_silence == $past(s_axi_wdata[8], 2)) else $error("mute not applied");
	AST_PH_COMMIT: assert property (wr_go && wr_ix == 8'h39 && s_axi_wstrb[0]
		&& s_axi_wdata[7:6] == 2'h2 |=> ##1 phones_left_pin_gain == $past(s_axi_wdata[5:0], 2))
		else $error("phones gain not committed");
	AST_LN_COMMIT: assert property (wr_go && wr_ix == 8'h3c && s_axi_wstrb[0]
		&& s_axi_wdata[7:6] == 2'h2 |=> ##1 line_right_pin_gain == $past(s_axi_wdata[5:0], 2))
		else $error("line gain not committed");
	AST_SLVERR: assert property (wr_go && (wr_ix < 8'h39 || wr_ix > 8'h3d)
		|=> ##1 s_axi_bresp == 2'h2)
		else $error("unmapped write not refused");
endmodule

bind output_volume_control output_volume_control_asserts #(.ZC_TIMEOUT_CYCLES(ZC_TIMEOUT_CYCLES)) chk (
	.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .phones_left_pin_gain,
	.line_right_pin_gain, .phones_left_pin_silence);

// ### tb/output_volume_control_tb_top.sv
// self-checking bench for the output volume control register bank
`timescale 1ns/1ps
module output_volume_control_tb_top;
	localparam [16:0] TOUT = 17'h14;     // short timeout keeps the run brief
	reg         aclk = 0;
	reg         aresetn = 0;
	reg  [9:0]  awaddr = 0, araddr = 0;
	reg  [31:0] wdata = 0;
	reg  [3:0]  wstrb = 0, zc = 0;       // zero-cross inputs, one per channel
	reg         awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	wire        awready, wready, bvalid, arready, rvalid;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata;
	wire [23:0] g;                       // line right, line left, phones right, phones left
	wire [3:0]  sil;
	reg  [31:0] rd;
	reg  [1:0]  rs;
	integer     n_errors = 0, n_tests = 0, i;
	output_volume_control #(.ZC_TIMEOUT_CYCLES(TOUT)) dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.phones_left_pin_zero_cross(zc[0]), .phones_right_pin_zero_cross(zc[1]),
		.line_left_pin_zero_cross(zc[2]), .line_right_pin_zero_cross(zc[3]),
		.phones_left_pin_gain(g[5:0]), .phones_right_pin_gain(g[11:6]),
		.line_left_pin_gain(g[17:12]), .line_right_pin_gain(g[23:18]),
		.phones_left_pin_silence(sil[0]), .phones_right_pin_silence(sil[1]),
		.line_left_pin_silence(sil[2]), .line_right_pin_silence(sil[3]));
	initial begin
		forever #5 aclk = ~aclk;
	end
	////////////////////////////////////////////////////////////////
	task check(input string nm, input [31:0] seen, input [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// a hung handshake counts against the run and ends it
	task limit(input integer k);
		if (k == 50) begin
			n_errors++;
			print_verdict;
		end
	endtask
	// write: address and data offered together, each released once taken
	task wr(input [7:0] ix, input [31:0] d, input [3:0] st);
		integer k;
		reg a, w, b;
		awaddr <= {ix, 2'h0};
		wdata <= d;
		wstrb <= st;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		b = 0;
		for (k = 0; !b; k++) begin
			limit(k);
			#1 a = awvalid & awready;
			w = wvalid & wready;
			b = bvalid;
			rs = bresp;
			@(posedge aclk);
			if (a) awvalid <= 0;
			if (w) wvalid <= 0;
		end
		// bready stays high between writes, never set twice at one edge
	endtask
	task rdr(input [7:0] ix);
		integer k;
		reg a, r;
		araddr <= {ix, 2'h0};
		arvalid <= 1;
		rready <= 1;
		r = 0;
		for (k = 0; !r; k++) begin
			limit(k);
			#1 a = arvalid & arready;
			r = rvalid;
			rd = rdata;
			rs = rresp;
			@(posedge aclk);
			if (a) arvalid <= 0;
		end
		// rready stays high between reads, never set twice at one edge
	endtask
	task cg(input [23:0] e);
		#1 check("gains", g, e);
		// next stimulus starts on a rising edge
		@(posedge aclk);
	endtask
	// one-cycle crossing on the masked channels
	task pulse(input [3:0] m);
		zc <= m;
		@(posedge aclk);
		zc <= 0;
		@(posedge aclk);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		// reset state of all four channels
		for (i = 0; i < 4; i++) begin
			rdr(8'h39 + i);
			check("reset", rd, i < 2 ? 32'h2d : 32'h39);
		end
		cg({6'h39, 6'h39, 6'h2d, 6'h2d});
		check("silence", sil, 4'h0);
		$display("test reset done");
		// staged gain, then commit from the other register of the pair
		wr(8'h39, 32'h3f, 4'h1);
		rdr(8'h39);
		check("staged", rd, 32'h3f);
		cg({6'h39, 6'h39, 6'h2d, 6'h2d});
		wr(8'h3a, 32'h80, 4'h1);
		cg({6'h39, 6'h39, 6'h00, 6'h3f});
		rdr(8'h3a);
		check("commit read", rd, 32'h0);
		wr(8'h3b, 32'h05, 4'h1);
		wr(8'h3c, 32'hba, 4'h1);
		cg({6'h3a, 6'h05, 6'h00, 6'h3f});
		$display("test commit done");
		// mute the channels one by one, earlier ones staying muted, gains untouched
		for (i = 0; i < 4; i++) begin
			wr(8'h39 + i, 32'h100, 4'h2);
			#1 check("silence", sil, (2 << i) - 1);
			@(posedge aclk);
		end
		rdr(8'h3c);
		check("mute read", rd, 32'h13a);
		for (i = 0; i < 4; i++) wr(8'h39 + i, 32'h0, 4'h2);
		#1 check("unmute", sil, 4'h0);
		cg({6'h3a, 6'h05, 6'h00, 6'h3f});
		$display("test silence done");
		// zero-cross gating, each phones channel waits for its own crossing
		wr(8'h39, 32'h50, 4'h1);
		wr(8'h3a, 32'he0, 4'h1);
		cg({6'h3a, 6'h05, 6'h00, 6'h3f});
		rdr(8'h3e);
		check("pending", rd, 32'h3);
		pulse(4'h1);
		cg({6'h3a, 6'h05, 6'h00, 6'h10});
		pulse(4'h2);
		cg({6'h3a, 6'h05, 6'h20, 6'h10});
		$display("test zero cross done");
		// line pair pending with no crossing: timeout only once enabled
		wr(8'h3b, 32'h47, 4'h1);
		wr(8'h3c, 32'hc8, 4'h1);
		repeat (2 * TOUT) @(posedge aclk);
		cg({6'h3a, 6'h05, 6'h20, 6'h10});
		wr(8'h3d, 32'h1, 4'h1);
		repeat (TOUT - 3) @(posedge aclk);
		cg({6'h3a, 6'h05, 6'h20, 6'h10});
		repeat (5) @(posedge aclk);
		cg({6'h08, 6'h07, 6'h20, 6'h10});
		$display("test timeout done");
		// refused places on the bus, then a control readback
		wr(8'h10, 32'h3f, 4'h3);
		check("bresp unmapped", rs, 2'h2);
		wr(8'h3e, 32'hf, 4'h1);
		check("bresp status", rs, 2'h2);
		rdr(8'h10);
		check("rdata unmapped", rd, 32'h0);
		check("rresp unmapped", rs, 2'h2);
		rdr(8'h3d);
		check("control", rd, 32'h1);
		// phones commit from the left register with zc off, right still waits
		wr(8'h39, 32'h85, 4'h1);
		check("bresp okay", rs, 2'h0);
		rdr(8'h3e);
		check("pending mix", rd, 32'h2);
		cg({6'h08, 6'h07, 6'h20, 6'h05});
		$display("test bus done");
		print_verdict;
	end
endmodule
